// ===== design/ddr_lane_pkg.sv
// Shared constants and types for the column command and data lane link.
package ddr_lane_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W    = 16;
  localparam int BANK_W    = 2;
  localparam int COL_W     = 8;
  localparam int MEM_AW    = 6;   // Bank plus the low four column bits.
  localparam int MEM_WORDS = 64;
  localparam int BANKS     = 4;
  localparam int LANES     = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_PERIOD_NS  = 10;
  localparam int LINK_PERIOD_NS = 160;
  // Reference cycles in one half of the link clock, and in a quarter.
  localparam int CK_HALF = LINK_PERIOD_NS / REF_PERIOD_NS / 2;
  localparam int CK_QTR  = CK_HALF / 2;
  localparam logic [3:0] CK_HALF_LAST = 4'(CK_HALF - 1);
  localparam logic [4:0] WR_LAST      = 5'(CK_HALF + 3 * CK_QTR - 1);

  // ----------------------------------------------------------------
  // Command codes on {select, row strobe, column strobe, write select}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_DESELECT  = 4'h8;
  localparam logic [3:0] CMD_NOP       = 4'h7;
  localparam logic [3:0] CMD_READ      = 4'h5;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;

  // Requests that the controller user may issue.
  typedef enum logic [1:0] {
    OP_READ      = 2'h0,
    OP_WRITE     = 2'h1,
    OP_ACTIVATE  = 2'h2,
    OP_PRECHARGE = 2'h3
  } op_type;

  // Word index of one beat of a two-word burst; the second beat flips
  // the low column bit, which gives both documented burst orders.
  function automatic logic [MEM_AW-1:0] word_index(input logic [BANK_W-1:0] bank,
                                                   input logic [COL_W-1:0]  col,
                                                   input logic              beat);
    word_index = {bank, col[3:1], col[0] ^ beat};
  endfunction

endpackage

// ===== design/ddr_link_if.sv
// Pin bundle between the memory controller and the memory device.
`timescale 1ns/1ps
interface ddr_link_if;
  logic        ck;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  bank_select;
  logic [7:0]  addr;
  logic        lower_write_mask;
  logic        upper_write_mask;
  // Each party drives its own copy; the enables are active low.
  logic [15:0] ctl_data_out;
  logic        ctl_data_oe_n;
  logic [1:0]  ctl_strobe_out;
  logic        ctl_strobe_oe_n;
  logic [15:0] dev_data_out;
  logic        dev_data_oe_n;
  logic [1:0]  dev_strobe_out;
  logic        dev_strobe_oe_n;
  wire  [15:0] data_bus;
  wire         lower_byte_strobe;
  wire         upper_byte_strobe;

  // An idle line reads low, as if held by termination.
  assign data_bus = !ctl_data_oe_n ? ctl_data_out :
                    !dev_data_oe_n ? dev_data_out : 16'h0000;
  assign lower_byte_strobe = !ctl_strobe_oe_n ? ctl_strobe_out[0] :
                             !dev_strobe_oe_n ? dev_strobe_out[0] : 1'b0;
  assign upper_byte_strobe = !ctl_strobe_oe_n ? ctl_strobe_out[1] :
                             !dev_strobe_oe_n ? dev_strobe_out[1] : 1'b0;

  modport controller (
    output ck, cs_n, ras_n, cas_n, we_n, bank_select, addr,
    output lower_write_mask, upper_write_mask,
    output ctl_data_out, ctl_data_oe_n, ctl_strobe_out, ctl_strobe_oe_n,
    input  data_bus, lower_byte_strobe, upper_byte_strobe
  );

  modport device (
    input  ck, cs_n, ras_n, cas_n, we_n, bank_select, addr,
    input  lower_write_mask, upper_write_mask,
    output dev_data_out, dev_data_oe_n, dev_strobe_out, dev_strobe_oe_n,
    input  data_bus, lower_byte_strobe, upper_byte_strobe
  );
endinterface

// ===== design/ddr_controller_end.sv
// Controller end: makes the link clock, issues commands, moves burst data.
`timescale 1ns/1ps
module ddr_controller_end (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  ddr_link_if.controller              link,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire ddr_lane_pkg::op_type   req_op,
  input  wire logic [1:0]             req_bank,
  input  wire logic [7:0]             req_col,
  input  wire logic [15:0]            req_wdata0,
  input  wire logic [15:0]            req_wdata1,
  input  wire logic [1:0]             req_mask0,
  input  wire logic [1:0]             req_mask1,
  output logic                        rd_valid,
  input  wire logic                   rd_ready,
  output logic [15:0]                 rd_data
);

  typedef enum logic [4:0] {
    C_IDLE = 5'h01,
    C_CMD  = 5'h02,
    C_WR   = 5'h04,
    C_RD   = 5'h08,
    C_PUSH = 5'h10
  } cstate_type;

  cstate_type  state;
  logic [3:0]  ck_cnt;
  logic        ck;
  logic [3:0]  cmd;
  logic [15:0] wdata [2];
  logic [1:0]  wmask [2];
  logic        op_write;
  logic        op_read;
  logic [4:0]  wr_cnt;
  logic [17:0] sync1;
  logic [17:0] sync2;
  logic [1:0]  strobe_q;
  logic [1:0]  beat_cnt [2];
  logic [15:0] rbuf [2];
  logic        push_idx;
  logic [15:0] fifo [2];
  logic        fifo_wp;
  logic        fifo_rp;
  logic [1:0]  fifo_cnt;

  // ----------------------------------------------------------------
  // Link clock and command timing
  // ----------------------------------------------------------------
  // Commands change on the falling link edge, so they are settled at the rise.
  wire fall_tick  = ck && (ck_cnt == ddr_lane_pkg::CK_HALF_LAST);
  wire half_tick  = (ck_cnt == ddr_lane_pkg::CK_HALF_LAST);
  wire fifo_empty = (fifo_cnt == 2'h0);
  wire fifo_full  = (fifo_cnt == 2'h2);
  // A new request waits until the read buffer has drained completely.
  assign req_ready = (state == C_IDLE) && fall_tick && fifo_empty;
  wire accept     = req_valid && req_ready;
  wire push_valid = (state == C_PUSH);
  wire push_fire  = push_valid && !fifo_full;
  wire pop_fire   = rd_valid && rd_ready;
  wire [1:0] s_strobe = sync2[17:16];
  wire [1:0] strobe_edge = s_strobe ^ strobe_q;
  wire rd_done    = (beat_cnt[0] == 2'h2) && (beat_cnt[1] == 2'h2);
  wire [3:0] req_cmd = (req_op == ddr_lane_pkg::OP_READ)     ? ddr_lane_pkg::CMD_READ :
                       (req_op == ddr_lane_pkg::OP_WRITE)    ? ddr_lane_pkg::CMD_WRITE :
                       (req_op == ddr_lane_pkg::OP_ACTIVATE) ? ddr_lane_pkg::CMD_ACTIVATE :
                                                               ddr_lane_pkg::CMD_PRECHARGE;

  assign link.ck    = ck;
  assign link.cs_n  = cmd[3];
  assign link.ras_n = cmd[2];
  assign link.cas_n = cmd[1];
  assign link.we_n  = cmd[0];
  assign rd_valid   = !fifo_empty;
  assign rd_data    = fifo[fifo_rp];

  // Divider that makes the link clock from the reference clock.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ck_cnt <= 4'h0;
      ck     <= 1'b0;
    end else begin
      ck_cnt <= half_tick ? 4'h0 : ck_cnt + 4'h1;
      ck     <= half_tick ? !ck : ck;
    end
  end

  // ----------------------------------------------------------------
  // Request sequencer
  // ----------------------------------------------------------------
  // One command per link cycle, then deselect; reads and writes run a burst.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state            <= C_IDLE;
      cmd              <= ddr_lane_pkg::CMD_DESELECT;
      link.bank_select <= 2'h0;
      link.addr        <= 8'h00;
      op_write         <= 1'b0;
      op_read          <= 1'b0;
      push_idx         <= 1'b0;
    end else begin
      case (state)
        C_IDLE: begin
          if (accept) begin
            cmd              <= req_cmd; // [R2] [R9]
            link.bank_select <= req_bank;
            link.addr        <= req_col;
            op_write         <= (req_op == ddr_lane_pkg::OP_WRITE);
            op_read          <= (req_op == ddr_lane_pkg::OP_READ);
            state            <= C_CMD;
          end
        end
        C_CMD: begin
          if (fall_tick) begin
            cmd   <= ddr_lane_pkg::CMD_DESELECT;
            state <= op_write ? C_WR : (op_read ? C_RD : C_IDLE);
          end
        end
        C_WR: begin
          if (wr_cnt == ddr_lane_pkg::WR_LAST) begin
            state <= C_IDLE;
          end
        end
        C_RD: begin
          if (rd_done) begin
            push_idx <= 1'b0;
            state    <= C_PUSH;
          end
        end
        C_PUSH: begin
          if (push_fire) begin
            push_idx <= 1'b1;
            state    <= push_idx ? C_IDLE : C_PUSH;
          end
        end
        default: state <= C_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write burst drive
  // ----------------------------------------------------------------
  // The strobe edge falls mid-word so the device sees settled data and mask.
  wire       wr_beat  = (wr_cnt >= 5'(ddr_lane_pkg::CK_HALF + ddr_lane_pkg::CK_QTR));
  wire       wr_high  = (wr_cnt >= 5'(ddr_lane_pkg::CK_HALF)) &&
                        (wr_cnt <  5'(ddr_lane_pkg::CK_HALF + 2 * ddr_lane_pkg::CK_QTR));
  wire       wr_drive = (state == C_WR) && (wr_cnt != ddr_lane_pkg::WR_LAST);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_cnt                <= 5'h00;
      link.ctl_data_out     <= 16'h0000;
      link.ctl_data_oe_n    <= 1'b1;
      link.ctl_strobe_out   <= 2'h0;
      link.ctl_strobe_oe_n  <= 1'b1;
      link.lower_write_mask <= 1'b0;
      link.upper_write_mask <= 1'b0;
    end else begin
      wr_cnt                <= (state == C_WR) ? wr_cnt + 5'h01 : 5'h00;
      link.ctl_data_oe_n    <= !wr_drive; // [R11]
      link.ctl_strobe_oe_n  <= !wr_drive; // [R11]
      link.ctl_data_out     <= wdata[wr_beat]; // [R6]
      link.ctl_strobe_out   <= {2{wr_high}}; // [R4] [R3]
      link.lower_write_mask <= wmask[wr_beat][0];
      link.upper_write_mask <= wmask[wr_beat][1];
    end
  end

  // Burst data held for the write; no reset needed on a data store.
  always_ff @(posedge ref_clk) begin
    if (accept) begin
      wdata[0] <= req_wdata0;
      wdata[1] <= req_wdata1;
      wmask[0] <= req_mask0;
      wmask[1] <= req_mask1;
    end
  end

  // ----------------------------------------------------------------
  // Read capture and two-entry return buffer
  // ----------------------------------------------------------------
  // Data and strobe cross together, so the synced data is new at the edge.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1       <= 18'h00000;
      sync2       <= 18'h00000;
      strobe_q    <= 2'h0;
      beat_cnt[0] <= 2'h0;
      beat_cnt[1] <= 2'h0;
    end else begin
      sync1    <= {link.upper_byte_strobe, link.lower_byte_strobe, link.data_bus};
      sync2    <= sync1;
      strobe_q <= s_strobe;
      for (int l = 0; l < ddr_lane_pkg::LANES; l++) begin
        if (state != C_RD) begin
          beat_cnt[l] <= 2'h0;
        end else if (strobe_edge[l] && beat_cnt[l] != 2'h2) begin
          beat_cnt[l] <= beat_cnt[l] + 2'h1; // [R6]
        end
      end
    end
  end

  // Each byte lane is captured on its own strobe.
  always_ff @(posedge ref_clk) begin
    for (int l = 0; l < ddr_lane_pkg::LANES; l++) begin
      if (state == C_RD && strobe_edge[l] && beat_cnt[l] != 2'h2) begin
        rbuf[beat_cnt[l][0]][8*l +: 8] <= sync2[8*l +: 8]; // [R3]
      end
    end
    if (push_fire) begin
      fifo[fifo_wp] <= rbuf[push_idx];
    end
  end

  // Return buffer pointers; both pushes always fit, so a stalled reader only holds off the next request.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_wp  <= 1'b0;
      fifo_rp  <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      fifo_wp  <= fifo_wp ^ push_fire;
      fifo_rp  <= fifo_rp ^ pop_fire;
      fifo_cnt <= fifo_cnt + {1'b0, push_fire} - {1'b0, pop_fire};
    end
  end

endmodule

// ===== design/ddr_device_end.sv
// Device end: decodes column and bank commands and serves the data lanes.
`timescale 1ns/1ps

// How it works
// [R1] Column strobe and write select taken on rise.
// [R2] Column strobe low starts read or write.
// [R3] Each byte strobe times its own byte.
// [R4] Device strobes read edge-aligned; controller strobes writes.
// [R5] Masked write bytes are never stored.
// [R6] Words move on both strobe edges.
// [R7] Reads drive both bytes, never masked.
// [R8] Select high makes the edge ignored.
// [R9] Row strobe low activates or precharges bank.
// [R10] Commands and address sampled on clock rise.
// [R11] Only one party drives data and strobes.
module ddr_device_end (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  ddr_link_if.device      link,
  output logic [3:0]      bank_open,
  output logic            closed_access,
  output logic            write_done
);

  typedef enum logic [4:0] {
    D_IDLE   = 5'h01,
    D_WR     = 5'h02,
    D_RD_PRE = 5'h04,
    D_RD_HI  = 5'h08,
    D_RD_LO  = 5'h10
  } dstate_type;

  localparam int IN_W = 35;

  dstate_type    state;
  logic [IN_W-1:0] sync1;
  logic [IN_W-1:0] sync2;
  logic          ck_q;
  logic [1:0]    strobe_q;
  logic [1:0]    cur_bank;
  logic [7:0]    cur_col;
  logic [3:0]    ph_cnt;
  logic [1:0]    lane_cnt [2];
  logic [15:0]   mem [ddr_lane_pkg::MEM_WORDS];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // All link pins cross together so the command fields stay coherent.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1    <= '0;
      sync2    <= '0;
      ck_q     <= 1'b0;
      strobe_q <= 2'h0;
    end else begin
      sync1    <= {link.ck, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                   link.bank_select, link.addr,
                   link.upper_write_mask, link.lower_write_mask,
                   link.upper_byte_strobe, link.lower_byte_strobe, link.data_bus};
      sync2    <= sync1;
      ck_q     <= sync2[34];
      strobe_q <= sync2[17:16];
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Fields of the synced pins, and the rising edge of the link clock.
  wire        s_ck     = sync2[34];
  wire [3:0]  s_cmd    = sync2[33:30];
  wire [1:0]  s_bank   = sync2[29:28];
  wire [7:0]  s_col    = sync2[27:20];
  wire [1:0]  s_mask   = sync2[19:18];
  wire [1:0]  s_strobe = sync2[17:16];
  wire [15:0] s_data   = sync2[15:0];
  wire        ck_rise  = s_ck && !ck_q; // [R10] [R1]
  // Select high masks the whole command at this edge.
  wire        cmd_ok   = ck_rise && !s_cmd[3] && (state == D_IDLE); // [R8]
  wire        is_read  = cmd_ok && (s_cmd == ddr_lane_pkg::CMD_READ); // [R2]
  wire        is_write = cmd_ok && (s_cmd == ddr_lane_pkg::CMD_WRITE); // [R2]
  wire        is_act   = cmd_ok && (s_cmd == ddr_lane_pkg::CMD_ACTIVATE); // [R9]
  wire        is_pre   = cmd_ok && (s_cmd == ddr_lane_pkg::CMD_PRECHARGE); // [R9]
  wire [1:0]  s_edge   = s_strobe ^ strobe_q;
  wire        wr_fin   = (lane_cnt[0] == 2'h2) && (lane_cnt[1] == 2'h2);
  wire        ph_end   = (ph_cnt == ddr_lane_pkg::CK_HALF_LAST);

  // Open-bank record; an access to a closed bank is still served but flagged.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_open     <= 4'h0;
      closed_access <= 1'b0;
    end else begin
      if (is_act) begin
        bank_open[s_bank] <= 1'b1; // [R9]
      end else if (is_pre) begin
        bank_open[s_bank] <= 1'b0; // [R9]
      end
      closed_access <= (is_read || is_write) && !bank_open[s_bank];
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  // A read runs a preamble, a high half and a low half of the strobe.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= D_IDLE;
      cur_bank <= 2'h0;
      cur_col  <= 8'h00;
      ph_cnt   <= 4'h0;
      write_done <= 1'b0;
    end else begin
      write_done <= 1'b0;
      ph_cnt     <= (state == D_IDLE || ph_end) ? 4'h0 : ph_cnt + 4'h1;
      case (state)
        D_IDLE: begin
          if (is_read || is_write) begin
            cur_bank <= s_bank; // [R10]
            cur_col  <= s_col;
            state    <= is_read ? D_RD_PRE : D_WR;
          end
        end
        // A write that never brings two edges on each byte strobe holds the device here.
        D_WR: begin
          if (wr_fin) begin
            write_done <= 1'b1;
            state      <= D_IDLE;
          end
        end
        D_RD_PRE: begin
          if (ph_end) begin
            state <= D_RD_HI;
          end
        end
        D_RD_HI: begin
          if (ph_end) begin
            state <= D_RD_LO;
          end
        end
        D_RD_LO: begin
          if (ph_end) begin
            state <= D_IDLE;
          end
        end
        default: state <= D_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write capture
  // ----------------------------------------------------------------
  // Each lane counts its own strobe edges: the rise brings the first word.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lane_cnt[0] <= 2'h0;
      lane_cnt[1] <= 2'h0;
    end else begin
      for (int l = 0; l < ddr_lane_pkg::LANES; l++) begin
        if (state != D_WR) begin
          lane_cnt[l] <= 2'h0;
        end else if (s_edge[l] && lane_cnt[l] != 2'h2) begin
          lane_cnt[l] <= lane_cnt[l] + 2'h1; // [R6] [R3]
        end
      end
    end
  end

  // Storage has no reset; the mask travels with the byte it guards.
  always_ff @(posedge ref_clk) begin
    for (int l = 0; l < ddr_lane_pkg::LANES; l++) begin
      if (state == D_WR && s_edge[l] && lane_cnt[l] != 2'h2 && !s_mask[l]) begin
        mem[ddr_lane_pkg::word_index(cur_bank, cur_col, lane_cnt[l][0])][8*l +: 8]
          <= s_data[8*l +: 8]; // [R5] [R4] [R3]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read drive
  // ----------------------------------------------------------------
  // Data changes together with the strobe; the controller takes it at the synced strobe edge.
  wire        rd_drive = (state == D_RD_PRE) || (state == D_RD_HI) ||
                         (state == D_RD_LO && !ph_end);
  wire        rd_beat  = (state == D_RD_LO) || (state == D_RD_HI && ph_end);
  wire        rd_high  = (state == D_RD_HI && !ph_end) || (state == D_RD_PRE && ph_end);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.dev_data_out    <= 16'h0000;
      link.dev_data_oe_n   <= 1'b1;
      link.dev_strobe_out  <= 2'h0;
      link.dev_strobe_oe_n <= 1'b1;
    end else begin
      link.dev_data_oe_n   <= !rd_drive; // [R11]
      link.dev_strobe_oe_n <= !rd_drive; // [R11]
      link.dev_strobe_out  <= {2{rd_high}}; // [R4] [R3]
      // Both bytes always leave; no mask applies on the way out.
      link.dev_data_out    <=
        mem[ddr_lane_pkg::word_index(cur_bank, cur_col, rd_beat)]; // [R7] [R6]
    end
  end

endmodule

// ===== test/ddr_lanes_assertions.sv
// Concurrent checks on the link signals between the two ends.
`timescale 1ns/1ps
module ddr_lanes_assertions (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        ck,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  bank_select,
  input wire logic [7:0]  addr,
  input wire logic [15:0] ctl_data_out,
  input wire logic        ctl_data_oe_n,
  input wire logic [1:0]  ctl_strobe_out,
  input wire logic        ctl_strobe_oe_n,
  input wire logic [15:0] dev_data_out,
  input wire logic        dev_data_oe_n,
  input wire logic [1:0]  dev_strobe_out,
  input wire logic        dev_strobe_oe_n
);
  // ----------------------------------------------------------------
  // Command and lane checks
  // ----------------------------------------------------------------
  // Command pins move only with the falling link clock, so the device rise sees them settled.
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_cmd_on_fall: assert property ($changed(cmd) |-> $fell(ck))
    else $error("command pins changed away from a link clock fall");
  chk_cmd_held: assert property ($fell(cs_n) |=> $stable({cmd, bank_select, addr})[*8])
    else $error("command or address not held across the link clock rise");
  chk_data_one_driver: assert property (!(!ctl_data_oe_n && !dev_data_oe_n))
    else $error("both ends drive the data lines");
  chk_strobe_one_driver: assert property (!(!ctl_strobe_oe_n && !dev_strobe_oe_n))
    else $error("both ends drive the strobe lines");
  chk_read_needs_cmd: assert property ($fell(dev_data_oe_n) |->
    cmd == ddr_lane_pkg::CMD_READ)
    else $error("device drove data without a read command");
  chk_read_strobe_walk: assert property ($fell(dev_strobe_oe_n) |->
    ##8 dev_strobe_out == 2'b11 ##8 dev_strobe_out == 2'b00)
    else $error("read strobe did not give one rise and one fall");
  chk_read_edge_align: assert property (!dev_data_oe_n && $past(!dev_data_oe_n) &&
    $changed(dev_data_out) |-> $changed(dev_strobe_out))
    else $error("read data moved without a strobe edge");
  chk_write_strobe_walk: assert property ($fell(ctl_data_oe_n) |-> ctl_strobe_out == 2'b00
    ##8 ctl_strobe_out == 2'b11 ##8 ctl_strobe_out == 2'b00 ##4 ctl_data_oe_n)
    else $error("write strobe sequence broken");
  chk_write_centred: assert property (!ctl_data_oe_n && $past(!ctl_data_oe_n) &&
    $changed(ctl_data_out) |-> $stable(ctl_strobe_out))
    else $error("write data moved on a strobe edge");
  chk_lanes_together: assert property (!dev_strobe_oe_n |->
    dev_strobe_out[0] == dev_strobe_out[1])
    else $error("byte strobes split during a read");
endmodule

// ===== test/ddr_column_cmd_and_data_lanes_tb.sv
// Self-checking bench joining the controller end to the device end.
`timescale 1ns/1ps
module ddr_column_cmd_and_data_lanes_tb;
  logic                 ref_clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 req_valid = 1'b0;
  logic                 req_ready;
  ddr_lane_pkg::op_type req_op = ddr_lane_pkg::OP_READ;
  logic [1:0]           req_bank = 2'h0;
  logic [7:0]           req_col = 8'h00;
  logic [15:0]          req_wdata0 = 16'h0000;
  logic [15:0]          req_wdata1 = 16'h0000;
  logic [1:0]           req_mask0 = 2'h0;
  logic [1:0]           req_mask1 = 2'h0;
  logic                 rd_valid;
  logic                 rd_ready = 1'b0;
  logic [15:0]          rd_data;
  logic [3:0]           bank_open;
  logic                 closed_access;
  logic                 write_done;
  logic                 seen_closed = 1'b0;
  logic [15:0]          got0;
  logic [15:0]          got1;
  int                   err_count = 0;
  int                   tests_run = 0;
  int                   cycles = 0;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  ddr_link_if ddr_link_if_i ();
  ddr_controller_end ddr_controller_end_i (.ref_clk, .rst_b, .link(ddr_link_if_i), .req_valid,
    .req_ready, .req_op, .req_bank, .req_col, .req_wdata0, .req_wdata1, .req_mask0,
    .req_mask1, .rd_valid, .rd_ready, .rd_data);
  ddr_device_end ddr_device_end_i (.ref_clk, .rst_b, .link(ddr_link_if_i), .bank_open,
    .closed_access, .write_done);
  ddr_lanes_assertions ddr_lanes_assertions_i (.ref_clk, .rst_b, .ck(ddr_link_if_i.ck),
    .cs_n(ddr_link_if_i.cs_n), .ras_n(ddr_link_if_i.ras_n), .cas_n(ddr_link_if_i.cas_n),
    .we_n(ddr_link_if_i.we_n), .bank_select(ddr_link_if_i.bank_select),
    .addr(ddr_link_if_i.addr), .ctl_data_out(ddr_link_if_i.ctl_data_out),
    .ctl_data_oe_n(ddr_link_if_i.ctl_data_oe_n), .ctl_strobe_out(ddr_link_if_i.ctl_strobe_out),
    .ctl_strobe_oe_n(ddr_link_if_i.ctl_strobe_oe_n), .dev_data_out(ddr_link_if_i.dev_data_out),
    .dev_data_oe_n(ddr_link_if_i.dev_data_oe_n), .dev_strobe_out(ddr_link_if_i.dev_strobe_out),
    .dev_strobe_oe_n(ddr_link_if_i.dev_strobe_oe_n));

  // Clock, and a watchdog that catches a hang; the closed-bank pulse is kept sticky.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (closed_access === 1'b1) seen_closed <= 1'b1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare with case inequality so an unknown never matches.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Hold the request until the edge that samples req_ready high.
  task automatic issue(input ddr_lane_pkg::op_type op, input logic [1:0] bank,
      input logic [7:0] col, input logic [15:0] w0, input logic [15:0] w1,
      input logic [1:0] m0, input logic [1:0] m1);
    req_op <= op;
    req_bank <= bank;
    req_col <= col;
    req_wdata0 <= w0;
    req_wdata1 <= w1;
    req_mask0 <= m0;
    req_mask1 <= m1;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    while (req_ready !== 1'b1) @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask

  task automatic bank_cmd(input ddr_lane_pkg::op_type op, input logic [1:0] bank,
      input logic [3:0] exp);
    issue(op, bank, 8'h00, 16'h0000, 16'h0000, 2'h0, 2'h0);
    repeat (40) @(posedge ref_clk);
    check(bank_open, exp);
  endtask

  task automatic wr(input logic [1:0] bank, input logic [7:0] col, input logic [15:0] w0,
      input logic [15:0] w1, input logic [1:0] m0, input logic [1:0] m1);
    issue(ddr_lane_pkg::OP_WRITE, bank, col, w0, w1, m0, m1);
    while (write_done !== 1'b1) @(posedge ref_clk);
  endtask

  // The receiver stalls while both words wait in the buffer, then drains it.
  task automatic rd(input logic [1:0] bank, input logic [7:0] col);
    issue(ddr_lane_pkg::OP_READ, bank, col, 16'h0000, 16'h0000, 2'h0, 2'h0);
    while (rd_valid !== 1'b1) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    check(rd_valid, 1'b1);
    rd_ready <= 1'b1;
    @(posedge ref_clk);
    got0 = rd_data;
    @(posedge ref_clk);
    got1 = rd_data;
    rd_ready <= 1'b0;
    @(posedge ref_clk);
    check(rd_valid, 1'b0);
  endtask

  task automatic results();
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    check(bank_open, 4'h0);
    bank_cmd(ddr_lane_pkg::OP_ACTIVATE, 2'h0, 4'h1);
    bank_cmd(ddr_lane_pkg::OP_ACTIVATE, 2'h2, 4'h5);
    $display("test activate done");
    wr(2'h0, 8'h04, 16'ha5c3, 16'h3c5a, 2'h0, 2'h0);
    rd(2'h0, 8'h04);
    check(got0, 16'ha5c3);
    check(got1, 16'h3c5a);
    rd(2'h0, 8'h05);
    check(got0, 16'h3c5a);
    check(got1, 16'ha5c3);
    $display("test burst done");
    // Each word masks a different lane, so a swapped lane shows at once.
    wr(2'h0, 8'h04, 16'h1111, 16'h2222, 2'h1, 2'h2);
    rd(2'h0, 8'hf4);
    check(got0, 16'h11c3);
    check(got1, 16'h3c22);
    check(seen_closed, 1'b0);
    $display("test mask done");
    rd(2'h1, 8'h00);
    check(seen_closed, 1'b1);
    bank_cmd(ddr_lane_pkg::OP_PRECHARGE, 2'h2, 4'h1);
    bank_cmd(ddr_lane_pkg::OP_PRECHARGE, 2'h0, 4'h0);
    $display("test precharge done");
    results();
  end
endmodule
